// [slm_pkg.sv]
// package: constants and types of the serial link control and alarm block
package slm_pkg;
  // ------------------------------------------------------------------
  // register map and values after reset
  // ------------------------------------------------------------------
  localparam logic [11:0] OFS_PP1 = 12'h037;
  localparam logic [11:0] OFS_SOFT_TRIG = 12'h06C;
  localparam logic [11:0] OFS_PP2 = 12'h29A;
  localparam logic [11:0] OFS_PP3 = 12'h29B;
  localparam logic [11:0] OFS_PP4 = 12'h29C;
  localparam logic [7:0] RST_PP1 = 8'h4B;
  localparam logic [7:0] RST_PP2 = 8'h0F;
  localparam logic [7:0] RST_PP3 = 8'h04;
  localparam logic [7:0] RST_PP4 = 8'h1B;
  localparam logic [7:0] RST_SOFT_TRIG = 8'h00;
  // ------------------------------------------------------------------
  // alarm bit positions
  // ------------------------------------------------------------------
  localparam int NALM = 6;
  localparam int LANES = 8;
  localparam int ALM_CPLL = 0;
  localparam int ALM_SPLL = 1;
  localparam int ALM_LINK = 2;
  localparam int ALM_SYSREF = 3;
  localparam int ALM_CLK = 4;
  localparam int ALM_FIFO = 5;
  // ------------------------------------------------------------------
  // timing: core transition delay after a calibration trigger
  // ------------------------------------------------------------------
  localparam int LP_DELAY_MIN_SMP = 500;
  localparam int LP_DELAY_MAX_SMP = 1000;
  localparam int SMP_PER_MCLK = 1;
  // aim at the middle of the window so both bounds keep margin
  localparam int LP_DELAY_CYC =
    (LP_DELAY_MIN_SMP + LP_DELAY_MAX_SMP) / (2 * SMP_PER_MCLK);
  localparam logic [9:0] LP_DELAY_LAST = 10'(LP_DELAY_CYC - 1);
  localparam logic [7:0] FRAME_CNT_RST = 8'h00;
  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {TR_IDLE, TR_WAIT} slm_trig_state_t;
endpackage

// [slm_sticky.sv]
// sticky flag vector: hardware sets, write-one clears, set wins
`timescale 1ns/10ps
module slm_sticky #(
  parameter int W = 6
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [W-1:0] set,
  input wire logic clr_wr,
  input wire logic [W-1:0] clr,
  output logic [W-1:0] flags
);
  import slm_pkg::*;

  // ------------------------------------------------------------------
  // flag storage
  // ------------------------------------------------------------------
  // a set in the clearing cycle survives so no event is lost
  always_ff @(posedge mclk) begin
    if (rst) begin
      flags <= '0;
    end else if (ce) begin
      if (clr_wr) begin
        flags <= (flags & ~clr) | set;
      end else begin
        flags <= flags | set;
      end
    end
  end
endmodule // slm_sticky

// [slm_frame_clk.sv]
// local multiframe / extended multiblock clock with sysref alignment
`timescale 1ns/10ps
module slm_frame_clk (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic run,
  input wire logic sysref_capture,
  input wire logic subclass0,
  input wire logic [7:0] frames_per_mf,
  output logic mf_edge,
  output logic realign
);
  import slm_pkg::*;

  logic [7:0] cnt;
  logic use_sysref;

  // subclass 0 ignores sysref: phase comes from enable time only
  assign use_sysref = sysref_capture && !subclass0;

  // ------------------------------------------------------------------
  // frame counter
  // ------------------------------------------------------------------
  // counter is held at zero while the link is off, so the phase starts at enable
  always_ff @(posedge mclk) begin
    if (rst || !run) begin
      cnt <= FRAME_CNT_RST;
      mf_edge <= 1'b0;
    end else if (ce) begin
      if (use_sysref) begin
        cnt <= FRAME_CNT_RST;
        mf_edge <= 1'b1;
      end else if (cnt == frames_per_mf) begin
        cnt <= FRAME_CNT_RST;
        mf_edge <= 1'b1;
      end else begin
        cnt <= cnt + 8'h01;
        mf_edge <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // realignment report
  // ------------------------------------------------------------------
  // a sysref that lands off the natural wrap moved the clock
  always_ff @(posedge mclk) begin
    if (rst || !run) begin
      realign <= 1'b0;
    end else if (ce) begin
      realign <= use_sysref && (cnt != frames_per_mf);
    end
  end
endmodule // slm_frame_clk

// [slm_link_ctrl.sv]
// link control, alarm supervision and low power trigger timing
`timescale 1ns/10ps
module slm_link_ctrl (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  output logic [7:0] reg_rdata,
  input wire logic link_enable,
  input wire logic [3:0] drive_emphasis_level,
  input wire logic enc_64b66b,
  input wire logic subclass0,
  input wire logic [7:0] frames_per_mf,
  input wire logic sysref_capture,
  input wire logic sync_request,
  input wire logic core_pll_locked,
  input wire logic ser_pll_locked,
  input wire logic link_in_data_state,
  input wire logic chan_a_clk,
  input wire logic chan_b_clk,
  input wire logic channel_a_powerdown,
  input wire logic channel_b_powerdown,
  input wire logic [slm_pkg::LANES-1:0] lane_fifo_fault,
  input wire logic alarm_clear_wr,
  input wire logic [slm_pkg::NALM-1:0] alarm_clear_bits,
  input wire logic [slm_pkg::LANES-1:0] lane_clear_bits,
  input wire logic [slm_pkg::NALM-1:0] alarm_mask_bits,
  input wire logic cal_status_sel,
  input wire logic cal_done,
  input wire logic lowpower_transition_trigger,
  input wire logic foreground_cal,
  input wire logic calibration_trigger_pin,
  output logic tx_logic_rst,
  output logic serializer_pd,
  output logic tx_clk_en,
  output logic fifo_reset,
  output logic [3:0] emphasis_drive,
  output logic lmfc_edge,
  output logic lemc_edge,
  output logic cgs_start,
  output logic [slm_pkg::NALM-1:0] alarm_status_bits,
  output logic [slm_pkg::LANES-1:0] lane_fifo_upset_flags,
  output logic clock_upset_flag,
  output logic alarm_summary,
  output logic cal_status_pin,
  output logic core_transition,
  output logic [7:0] power_profile_1,
  output logic [7:0] power_profile_2,
  output logic [7:0] power_profile_3,
  output logic [7:0] power_profile_4
);
  import slm_pkg::*;

  // ------------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------------
  logic [7:0] calibration_soft_trigger;
  logic mf_edge;
  logic realign;
  logic [NALM-1:0] alarm_set;
  logic soft_trig_hit;
  logic trig_pin_q;
  logic trig_event;
  slm_trig_state_t trig_state;
  logic [9:0] trig_cnt;
  logic [10:0] since_trig;

  // address match, used by both the write and the read paths
  function automatic logic hit(input logic [11:0] a,
                               input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction

  // ------------------------------------------------------------------
  // link enable gating
  // ------------------------------------------------------------------
  // registered so reset and clock gate change together on one edge
  always_ff @(posedge mclk) begin
    if (rst) begin
      tx_logic_rst <= 1'b1;
      serializer_pd <= 1'b1;
      tx_clk_en <= 1'b0;
      fifo_reset <= 1'b1;
    end else if (ce) begin
      tx_logic_rst <= !link_enable;
      serializer_pd <= !link_enable;
      tx_clk_en <= link_enable;
      fifo_reset <= !link_enable;
    end
  end

  // ------------------------------------------------------------------
  // drive emphasis
  // ------------------------------------------------------------------
  // level is copied unchanged while the link is enabled and held while it is off; drivers scale monotonic with it
  always_ff @(posedge mclk) begin
    if (rst) begin
      emphasis_drive <= 4'h0;
    end else if (ce && link_enable) begin
      emphasis_drive <= drive_emphasis_level;
    end
  end

  // ------------------------------------------------------------------
  // frame clock and alignment start
  // ------------------------------------------------------------------
  slm_frame_clk u_frame (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .run(link_enable),
    .sysref_capture(sysref_capture),
    .subclass0(subclass0),
    .frames_per_mf(frames_per_mf),
    .mf_edge(mf_edge),
    .realign(realign)
  );

  // the one counter serves as either clock, named by the coding
  assign lmfc_edge = mf_edge && !enc_64b66b;
  assign lemc_edge = mf_edge && enc_64b66b;

  // sync request starts code group sync in either subclass
  always_ff @(posedge mclk) begin
    if (rst) begin
      cgs_start <= 1'b0;
    end else if (ce) begin
      cgs_start <= link_enable && !enc_64b66b && sync_request;
    end
  end

  // ------------------------------------------------------------------
  // alarm sources
  // ------------------------------------------------------------------
  // clock compare needs both channels up and the link running
  always_comb begin
    alarm_set = '0;
    alarm_set[ALM_CPLL] = !core_pll_locked;
    alarm_set[ALM_SPLL] = !ser_pll_locked;
    alarm_set[ALM_LINK] = !link_in_data_state;
    alarm_set[ALM_SYSREF] = realign;
    alarm_set[ALM_CLK] = link_enable && !channel_a_powerdown
      && !channel_b_powerdown && (chan_a_clk != chan_b_clk);
    alarm_set[ALM_FIFO] = |lane_fifo_fault;
  end

  slm_sticky #(.W(NALM)) u_alarm (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .set(alarm_set),
    .clr_wr(alarm_clear_wr),
    .clr(alarm_clear_bits),
    .flags(alarm_status_bits)
  );

  slm_sticky #(.W(LANES)) u_lane (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .set(lane_fifo_fault),
    .clr_wr(alarm_clear_wr),
    .clr(lane_clear_bits),
    .flags(lane_fifo_upset_flags)
  );

  assign clock_upset_flag = alarm_status_bits[ALM_CLK];

  // ------------------------------------------------------------------
  // summary alarm and status pin
  // ------------------------------------------------------------------
  // one cycle behind the status bits, so software sees a stable pair
  always_ff @(posedge mclk) begin
    if (rst) begin
      alarm_summary <= 1'b0;
    end else if (ce) begin
      alarm_summary <= |(alarm_status_bits & ~alarm_mask_bits);
    end
  end

  assign cal_status_pin = cal_status_sel ? alarm_summary : cal_done;

  // ------------------------------------------------------------------
  // power registers and soft trigger
  // ------------------------------------------------------------------
  // values are only taken by the analog side; order of writes is free
  always_ff @(posedge mclk) begin
    if (rst) begin
      power_profile_1 <= RST_PP1;
      power_profile_2 <= RST_PP2;
      power_profile_3 <= RST_PP3;
      power_profile_4 <= RST_PP4;
      calibration_soft_trigger <= RST_SOFT_TRIG;
    end else if (ce && reg_wr) begin
      if (hit(reg_addr, OFS_PP1)) begin
        power_profile_1 <= reg_wdata;
      end
      if (hit(reg_addr, OFS_PP2)) begin
        power_profile_2 <= reg_wdata;
      end
      if (hit(reg_addr, OFS_PP3)) begin
        power_profile_3 <= reg_wdata;
      end
      if (hit(reg_addr, OFS_PP4)) begin
        power_profile_4 <= reg_wdata;
      end
      if (hit(reg_addr, OFS_SOFT_TRIG)) begin
        calibration_soft_trigger <= reg_wdata;
      end
    end
  end

  // read data is registered; unmapped addresses read zero
  always_ff @(posedge mclk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (ce) begin
      if (hit(reg_addr, OFS_PP1)) begin
        reg_rdata <= power_profile_1;
      end else if (hit(reg_addr, OFS_PP2)) begin
        reg_rdata <= power_profile_2;
      end else if (hit(reg_addr, OFS_PP3)) begin
        reg_rdata <= power_profile_3;
      end else if (hit(reg_addr, OFS_PP4)) begin
        reg_rdata <= power_profile_4;
      end else if (hit(reg_addr, OFS_SOFT_TRIG)) begin
        reg_rdata <= calibration_soft_trigger;
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // ------------------------------------------------------------------
  // calibration trigger timing
  // ------------------------------------------------------------------
  assign soft_trig_hit = reg_wr && hit(reg_addr, OFS_SOFT_TRIG);

  // pin is synchronous; a rising level is one trigger
  always_ff @(posedge mclk) begin
    if (rst) begin
      trig_pin_q <= 1'b0;
    end else if (ce) begin
      trig_pin_q <= calibration_trigger_pin;
    end
  end

  assign trig_event = soft_trig_hit
    || (calibration_trigger_pin && !trig_pin_q);

  // a trigger during a running wait is dropped, not queued
  always_ff @(posedge mclk) begin
    if (rst) begin
      trig_state <= TR_IDLE;
      trig_cnt <= 10'h000;
      core_transition <= 1'b0;
    end else if (ce) begin
      core_transition <= 1'b0;
      case (trig_state)
        TR_IDLE: begin
          trig_cnt <= 10'h000;
          if (trig_event && lowpower_transition_trigger
              && !foreground_cal) begin
            trig_state <= TR_WAIT;
          end
        end
        TR_WAIT: begin
          if (foreground_cal) begin
            trig_state <= TR_IDLE;
          end else if (trig_cnt == LP_DELAY_LAST) begin
            core_transition <= 1'b1;
            trig_state <= TR_IDLE;
          end else begin
            trig_cnt <= trig_cnt + 10'h001;
          end
        end
        default: begin
          trig_state <= TR_IDLE;
        end
      endcase
    end
  end

  // helper for checks: cycles since the trigger was accepted
  always_ff @(posedge mclk) begin
    if (rst) begin
      since_trig <= 11'h000;
    end else if (ce) begin
      if (trig_state == TR_IDLE) begin
        since_trig <= 11'h000;
      end else begin
        since_trig <= since_trig + 11'h001;
      end
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  chk_link_off_hold: assert property (@(posedge mclk) disable iff (rst)
    ce && !link_enable |=> tx_logic_rst && serializer_pd && !tx_clk_en)
    else $error("tx section not held off while link disabled");
  chk_emph_follow: assert property (@(posedge mclk) disable iff (rst)
    ce && link_enable |=> emphasis_drive == $past(drive_emphasis_level))
    else $error("emphasis drive does not follow level");
  chk_sysref_edge: assert property (@(posedge mclk) disable iff (rst)
    ce && link_enable && !subclass0 && sysref_capture
    |=> (enc_64b66b ? lemc_edge : lmfc_edge))
    else $error("sysref did not reset the frame clock");
  chk_cgs_start: assert property (@(posedge mclk) disable iff (rst)
    ce && link_enable && !enc_64b66b && sync_request |=> cgs_start)
    else $error("sync request did not start code group sync");
  chk_alarm_hold: assert property (@(posedge mclk) disable iff (rst)
    ce && !alarm_clear_wr
    |=> (alarm_status_bits & $past(alarm_status_bits))
        == $past(alarm_status_bits))
    else $error("alarm bit dropped without a clear");
  chk_alarm_clear: assert property (@(posedge mclk) disable iff (rst)
    ce && alarm_clear_wr
    |=> (alarm_status_bits & $past(alarm_clear_bits)
         & ~$past(alarm_set)) == '0)
    else $error("write of one did not clear alarm bit");
  chk_summary_or: assert property (@(posedge mclk) disable iff (rst)
    ce |=> alarm_summary
      == |($past(alarm_status_bits) & ~$past(alarm_mask_bits)))
    else $error("summary alarm does not match unmasked bits");
  chk_cal_status_pin_alarm: assert property (@(posedge mclk) disable iff (rst)
    cal_status_sel && alarm_summary |-> cal_status_pin)
    else $error("status pin low during alarm");
  chk_clk_upset: assert property (@(posedge mclk) disable iff (rst)
    ce && link_enable && !channel_a_powerdown && !channel_b_powerdown
    && (chan_a_clk != chan_b_clk) |=> clock_upset_flag)
    else $error("clock mismatch not flagged");
  chk_lane_flag: assert property (@(posedge mclk) disable iff (rst)
    ce |=> (lane_fifo_upset_flags & $past(lane_fifo_fault))
      == $past(lane_fifo_fault))
    else $error("lane fifo upset not flagged");
  chk_fifo_reset: assert property (@(posedge mclk) disable iff (rst)
    ce && !link_enable ##1 ce && link_enable |-> fifo_reset ##1 !fifo_reset)
    else $error("link toggle did not pulse fifo reset");
  chk_trig_window: assert property (@(posedge mclk) disable iff (rst)
    core_transition |-> since_trig >= 11'(LP_DELAY_MIN_SMP / SMP_PER_MCLK)
      && since_trig <= 11'(LP_DELAY_MAX_SMP / SMP_PER_MCLK))
    else $error("core transition outside delay window");
  chk_no_fg_trans: assert property (@(posedge mclk) disable iff (rst)
    $past(foreground_cal) |-> !core_transition)
    else $error("core transition in foreground mode");
  cov_trigger: cover property (@(posedge mclk) disable iff (rst)
    core_transition);
  cov_clk_alarm: cover property (@(posedge mclk) disable iff (rst)
    !clock_upset_flag ##1 clock_upset_flag);
  cov_realign: cover property (@(posedge mclk) disable iff (rst)
    alarm_status_bits[ALM_SYSREF]);
endmodule // slm_link_ctrl

// [slm_rx_model.sv]
// far-side receiver model: sync request and elastic buffer release
`timescale 1ns/10ps
module slm_rx_model #(
  parameter int RBD = 0
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic lmfc_edge,
  input wire logic cgs_start,
  output logic sync_request,
  output logic released
);
  // ------------------------------------------------------------------
  // sync request and release point
  // ------------------------------------------------------------------
  int unsigned rbd_cnt;
  logic armed;
  // request holds until code group sync starts; dropped on a frame edge
  // so that alignment starts from a known phase of the frame clock
  always_ff @(posedge mclk) begin
    if (rst) begin
      sync_request <= 1'b1;
      armed <= 1'b0;
      rbd_cnt <= 0;
      released <= 1'b0;
    end else begin
      released <= 1'b0;
      if (cgs_start && lmfc_edge) begin
        sync_request <= 1'b0;
        armed <= 1'b1;
      end
      if (lmfc_edge) begin
        rbd_cnt <= 0;
      end else begin
        rbd_cnt <= rbd_cnt + 1;
      end
      // release only once armed by the sync drop, at the offset from the edge
      if (armed && rbd_cnt == RBD) begin
        released <= 1'b1;
      end
    end
  end
endmodule // slm_rx_model

// [slm_link_ctrl_test.sv]
// self-checking testbench of the link control and alarm block
`timescale 1ns/10ps
module slm_link_ctrl_test;
  import slm_pkg::*;
  // ------------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------------
  logic mclk = 0, rst = 1, ce = 1, reg_wr = 0, link_enable = 0;
  logic [11:0] reg_addr = 12'h0000;
  logic [7:0] reg_wdata = 8'h00, frames_per_mf = 8'h07, reg_rdata;
  logic [3:0] drive_emphasis_level = 4'h0, emphasis_drive;
  logic enc_64b66b = 0, subclass0 = 1, sysref_capture = 0, sync_request;
  logic core_pll_locked = 1, ser_pll_locked = 1, link_in_data_state = 1;
  logic chan_a_clk = 0, chan_b_clk = 0, channel_a_powerdown = 0;
  logic channel_b_powerdown = 0, alarm_clear_wr = 0, cal_status_sel = 1;
  logic [LANES-1:0] lane_fifo_fault = '0, lane_clear_bits = '0;
  logic [LANES-1:0] lane_fifo_upset_flags;
  logic [NALM-1:0] alarm_clear_bits = '0, alarm_mask_bits = '0;
  logic [NALM-1:0] alarm_status_bits;
  logic cal_done = 0, lowpower_transition_trigger = 1, foreground_cal = 0;
  logic calibration_trigger_pin = 0, tx_logic_rst, serializer_pd;
  logic tx_clk_en, fifo_reset, lmfc_edge, lemc_edge, cgs_start;
  logic clock_upset_flag, alarm_summary, cal_status_pin, core_transition;
  logic released;
  logic [7:0] power_profile_1, power_profile_2;
  logic [7:0] power_profile_3, power_profile_4;
  int mismatches = 0, n_checks = 0;
  // ------------------------------------------------------------------
  // clock, design and far-side model
  // ------------------------------------------------------------------
  always #2 mclk = ~mclk;
  slm_link_ctrl i_dut (.*);
  slm_rx_model i_rx (.*);
  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(negedge mclk);
    reg_addr = a;
    @(negedge mclk);
    chk(32'(reg_rdata), 32'(exp));
  endtask
  // bounded wait; running out counts a mismatch and ends the run
  task automatic wait_hi(ref logic s, input int lim);
    int n;
    n = 0;
    while (s !== 1'b1) begin
      @(negedge mclk);
      n++;
      if (n > lim) begin
        mismatches++;
        summarize();
      end
    end
  endtask
  task automatic clr(input logic [NALM-1:0] b, input logic [LANES-1:0] l);
    @(negedge mclk);
    alarm_clear_wr = 1'b1;
    alarm_clear_bits = b;
    lane_clear_bits = l;
    @(negedge mclk);
    alarm_clear_wr = 1'b0;
  endtask
  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_regs();
    logic [11:0] ofs [4] = '{OFS_PP1, OFS_PP2, OFS_PP3, OFS_PP4};
    logic [7:0] lp [4] = '{8'h46, 8'h06, 8'h00, 8'h14};
    logic [7:0] hp [4] = '{8'h4B, 8'h0F, 8'h04, 8'h1B};
    rd(OFS_SOFT_TRIG, 8'h00);
    for (int i = 0; i < 4; i++) begin
      rd(ofs[i], hp[i]);
      wr(ofs[i], lp[i]);
      rd(ofs[i], lp[i]);
    end
    chk({power_profile_1, power_profile_2, power_profile_3,
         power_profile_4}, 32'h4606_0014);
    // unmapped write must leave every register alone
    wr(12'h0100, 8'hFF);
    rd(12'h0100, 8'h00);
    // a write with the clock enable low must not land either
    ce = 1'b0;
    wr(OFS_PP1, 8'hFF);
    ce = 1'b1;
    chk({power_profile_1, power_profile_2, power_profile_3,
         power_profile_4}, 32'h4606_0014);
    for (int i = 0; i < 4; i++) begin
      wr(ofs[i], hp[i]);
    end
    chk({power_profile_1, power_profile_2, power_profile_3,
         power_profile_4}, 32'h4B0F_041B);
    $display("test regs done");
  endtask
  task automatic t_link();
    chk({tx_logic_rst, serializer_pd, tx_clk_en, fifo_reset}, 4'hD);
    @(negedge mclk);
    drive_emphasis_level = 4'hA;
    @(negedge mclk);
    link_enable = 1'b1;
    @(negedge mclk);
    chk({tx_logic_rst, serializer_pd, tx_clk_en, fifo_reset}, 4'h2);
    chk(emphasis_drive, 4'hA);
    wait_hi(cgs_start, 100);
    wait_hi(lmfc_edge, 20);
    link_enable = 1'b0;
    @(negedge mclk);
    chk(fifo_reset, 1'b1);
    link_enable = 1'b1;
    @(negedge mclk);
    chk(fifo_reset, 1'b0);
    wait_hi(released, 20);
    $display("test link done");
  endtask
  task automatic t_clk();
    clr(6'h3F, 8'hFF);
    chk(alarm_status_bits, 6'h00);
    chan_a_clk = 1'b1;
    @(negedge mclk);
    chan_a_clk = 1'b0;
    chk(clock_upset_flag, 1'b1);
    chk(alarm_status_bits, 6'h10);
    @(negedge mclk);
    chk(alarm_summary, 1'b1);
    chk(cal_status_pin, 1'b1);
    cal_status_sel = 1'b0;
    @(negedge mclk);
    chk(cal_status_pin, 1'b0);
    cal_status_sel = 1'b1;
    clr(6'h2F, 8'h00);
    chk(clock_upset_flag, 1'b1);
    alarm_mask_bits = 6'h10;
    repeat (2) @(negedge mclk);
    chk(alarm_summary, 1'b0);
    alarm_mask_bits = 6'h00;
    clr(6'h10, 8'h00);
    chk(clock_upset_flag, 1'b0);
    @(negedge mclk);
    chk(alarm_summary, 1'b0);
    $display("test clock alarm done");
  endtask
  task automatic t_fifo();
    @(negedge mclk);
    lane_fifo_fault = 8'h04;
    @(negedge mclk);
    lane_fifo_fault = 8'h00;
    chk(lane_fifo_upset_flags, 8'h04);
    chk(alarm_status_bits, 6'h20);
    clr(6'h20, 8'h04);
    chk(lane_fifo_upset_flags, 8'h00);
    $display("test fifo done");
  endtask
  // one-cycle drop of each lock or data state sets its own bit
  task automatic t_src();
    @(negedge mclk);
    core_pll_locked = 1'b0;
    ser_pll_locked = 1'b0;
    link_in_data_state = 1'b0;
    @(negedge mclk);
    core_pll_locked = 1'b1;
    ser_pll_locked = 1'b1;
    link_in_data_state = 1'b1;
    chk(alarm_status_bits, 6'h07);
    clr(6'h07, 8'h00);
    chk(alarm_status_bits, 6'h00);
    $display("test alarm sources done");
  endtask
  // sysref off the natural wrap restarts the clock and flags a realign
  task automatic t_sysref(input logic enc);
    @(negedge mclk);
    link_enable = 1'b0;
    @(negedge mclk);
    subclass0 = 1'b0;
    enc_64b66b = enc;
    @(negedge mclk);
    link_enable = 1'b1;
    repeat (3) @(negedge mclk);
    sysref_capture = 1'b1;
    @(negedge mclk);
    sysref_capture = 1'b0;
    chk({lmfc_edge, lemc_edge}, {!enc, enc});
    @(negedge mclk);
    chk(alarm_status_bits, 6'h08);
    clr(6'h08, 8'h00);
    chk(alarm_status_bits, 6'h00);
    $display("test sysref done");
  endtask
  // trigger by pin or soft write; foreground entered in the first wait cycle kills it
  task automatic t_trig(input logic fg, input logic pin);
    int n;
    n = 0;
    @(negedge mclk);
    if (pin) begin
      calibration_trigger_pin = 1'b1;
      @(negedge mclk);
      calibration_trigger_pin = 1'b0;
    end else begin
      wr(OFS_SOFT_TRIG, 8'h01);
    end
    foreground_cal = fg;
    while (core_transition !== 1'b1 && n < 1100) begin
      @(negedge mclk);
      n++;
    end
    chk(32'(n + 1 >= 500 && n + 1 <= 1000), 32'(!fg));
    @(negedge mclk);
    chk(core_transition, 1'b0);
    foreground_cal = 1'b0;
    $display("test trigger done");
  endtask
  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (8) @(negedge mclk);
    rst = 1'b0;
    t_regs();
    t_link();
    t_clk();
    t_fifo();
    t_src();
    t_sysref(1'b0);
    t_sysref(1'b1);
    t_trig(1'b0, 1'b0);
    t_trig(1'b0, 1'b1);
    t_trig(1'b1, 1'b0);
    summarize();
  end
endmodule // slm_link_ctrl_test
